// >>> ssmc_host_model.sv
// host model that writes the serial control port of the spindle block
// assumes the bench calls write_word and noise one at a time
`timescale 1ns/1ps
module ssmc_host_model (
  output logic sclk_o,
  output logic chip_sel_n_o,
  output logic serial_data_o
);
  initial begin
    sclk_o = 1'b0;
    chip_sel_n_o = 1'b1;
    serial_data_o = 1'b0;
  end
  // n clocks, bit n-1 first, so sleep_run_bit is always last
  task automatic write_word(input logic [31:0] w, input int n);
    #13;
    sclk_o = 1'b0; // clock parked low before select falls
    #20;
    chip_sel_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_o = w[i];
      #40 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
    #20 chip_sel_n_o = 1'b1;
    // released line shows the inverse, so a late sample cannot match by luck
    serial_data_o = ~serial_data_o;
    #60;
  endtask
  // clock and data move while deselected
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) begin
      serial_data_o = ~serial_data_o;
      #40 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
    #60;
  endtask
endmodule

// >>> ssmc_pkg.sv
// shared constants and types of the spindle serial mode control block
// assumes one core clock that also serves as the speed reference oscillator
package ssmc_pkg;

  localparam int CW_W = 24;
  localparam logic [23:0] CW_RST = 24'h000000;
  localparam int SPD_W = 14;
  localparam int SPD_LSB = 5;
  // weight of the lowest speed count bit is 16 = 2**4
  localparam int SPD_WEIGHT_SHIFT = 4;
  localparam int REF_W = 18;
  localparam int ZC_PER_POLE = 3;
  localparam int ZC_CNT_W = 6;

  localparam logic [4:0] POLES_8 = 5'h08;
  localparam logic [4:0] POLES_16 = 5'h10;
  localparam logic [4:0] POLES_12 = 5'h0c;

  // sync flag window between the two falling edges, in core clock cycles
  localparam int SYNC_TOL_CYC = 16;
  localparam logic [4:0] PIN_SYNC_RST = 5'h01;

  typedef enum logic [1:0] {
    ILIM_SAT = 2'h0,
    ILIM_1A = 2'h1,
    ILIM_800MA = 2'h2,
    ILIM_600MA = 2'h3
  } ssmc_ilim_e;

  typedef enum logic [1:0] {
    POLE_8 = 2'h0,
    POLE_UNDEF = 2'h1,
    POLE_16 = 2'h2,
    POLE_12 = 2'h3
  } ssmc_pole_e;

  typedef enum logic [1:0] {
    OSEL_TICK = 2'h0,
    OSEL_THERM = 2'h1,
    OSEL_SYNC = 2'h2,
    OSEL_ZC = 2'h3
  } ssmc_osel_e;

  // motor_control_word, bit 23 first down to bit 0
  typedef struct packed {
    logic osel_b23;
    logic osel_b22;
    logic pole_b21;
    logic pole_b20;
    logic speed_source_bit;
    logic [SPD_W-1:0] speed_count_field;
    logic ilim_b4;
    logic ilim_b3;
    logic brake_bit;
    logic step_only_bit;
    logic sleep_run_bit;
  } ssmc_ctrl_s;

  // asynchronous pins that pass the two-stage synchroniser, cs_n in bit 0
  typedef struct packed {
    logic thermal;
    logic zero_cross;
    logic index;
    logic brake;
    logic cs_n;
  } ssmc_pins_s;

endpackage

// >>> ssmc_sync.sv
// two flip-flop synchroniser for a group of level inputs
// assumes the inputs are levels that stay put for several clock cycles
`timescale 1ns/1ps
module ssmc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ssmc_sync_st_s;

  ssmc_sync_st_s st_r;
  ssmc_sync_st_s st_nxt;

  // the first stage feeds only the second
  always_comb begin
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_r <= {RST, RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2;
endmodule

// >>> ssmc_top.sv
// spindle serial mode control: serial word capture, modes, brake, speed loop
// assumes sclk_i comes from the host and may keep running between writes; pins are async
// Summary of operation
// - index source drives the revolution tick
// - preset at startup forces max current clamp
// - first overspeed event clears preset
// - brake: high sides off, low sides on
// - brake from pin or brake bit
// - brake stays latched until reset
// - chip select high ignores serial activity
// - shift data on rising serial clock
// - latch word on chip select rising edge
// - reset clears all bits, forces sleep
// - sleep_run_bit low sleeps, high runs
// - step only disables back-emf commutation
// - current limit field selects limit
// - active-low speed count sets reference length
// - speed_source_bit picks internal or index
// - pole count field sets revolution counter
// - output select field drives diagnostic output
// - revolution tick from counted zero-cross toggles
// - reference interval starts on tick rise
// - speed error from falling edge difference
`timescale 1ns/1ps
module ssmc_top
  import ssmc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic sclk_i,
  input wire logic chip_sel_n_i,
  input wire logic serial_data_i,
  input wire logic brake_pin_i,
  input wire logic index_i,
  input wire logic zero_cross_toggle_i,
  input wire logic thermal_shdn_i,
  output logic run_o,
  output logic step_only_o,
  output logic bemf_commutate_en_o,
  output logic high_side_off_o,
  output logic [2:0] low_side_on_o,
  output logic [1:0] current_limit_o,
  output logic [4:0] pole_count_o,
  output logic speed_loop_preset_o,
  output logic revolution_tick_o,
  output logic speed_ref_o,
  output logic speed_fast_o,
  output logic speed_slow_o,
  output logic speed_sync_o,
  output logic data_out_o
);

  localparam logic [REF_W-1:0] SYNC_TOL = REF_W'(SYNC_TOL_CYC);

  // serial clock domain: only the shift word lives here
  typedef struct packed {
    logic [CW_W-1:0] shift;
  } ssmc_link_s;

  ssmc_link_s lnk_r;
  ssmc_link_s lnk_nxt;

  always_comb begin
    lnk_nxt = lnk_r;
    if (!chip_sel_n_i) begin
      // older bits fall off the top, so the last 24 stay
      lnk_nxt.shift = {lnk_r.shift[CW_W-2:0], serial_data_i};
    end
  end

  // chip select high leaves the shift word untouched
  always_ff @(posedge sclk_i) begin
    lnk_r <= lnk_nxt;
  end

  // core domain
  ssmc_pins_s pin_raw;
  ssmc_pins_s pin_s;

  assign pin_raw = '{thermal: thermal_shdn_i, zero_cross: zero_cross_toggle_i,
                     index: index_i, brake: brake_pin_i, cs_n: chip_sel_n_i};

  ssmc_sync #(
    .W(5),
    .RST(PIN_SYNC_RST)
  ) u_pin_sync (
    .clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  typedef struct packed {
    ssmc_ctrl_s ctrl;
    logic cs_prev;
    logic zc_prev;
    logic tick_prev;
    logic int_tick;
    logic [ZC_CNT_W-1:0] zc_cnt;
    logic ref_hi;
    logic [REF_W-1:0] ref_cnt;
    logic armed;
    logic [REF_W-1:0] diff_cnt;
    logic preset;
    logic brake;
    logic fast;
    logic slow;
    logic sync;
    logic data_out;
    logic run;
    logic step;
    logic bemf_en;
    logic [1:0] ilim;
    logic [4:0] poles;
  } ssmc_core_s;

  ssmc_core_s st_r;
  ssmc_core_s st_nxt;

  logic cs_rise;
  logic tick_sel;
  logic tick_rise;
  logic tick_fall;
  logic zc_edge;
  logic [REF_W-1:0] ref_total;
  logic [4:0] poles_now;
  logic [ZC_CNT_W-1:0] zc_limit;

  assign cs_rise = pin_s.cs_n & ~st_r.cs_prev;
  // external index replaces the internally counted once-around
  assign tick_sel = st_r.ctrl.speed_source_bit ? pin_s.index : st_r.int_tick;
  assign tick_rise = tick_sel & ~st_r.tick_prev;
  assign tick_fall = ~tick_sel & st_r.tick_prev;
  assign zc_edge = pin_s.zero_cross ^ st_r.zc_prev;
  // bits programmed low add their weight 16..131072
  assign ref_total = {~st_r.ctrl.speed_count_field, 4'h0};
  assign zc_limit = ZC_CNT_W'(ZC_PER_POLE * int'(st_r.poles));

  always_comb begin
    unique case (ssmc_pole_e'({st_r.ctrl.pole_b20, st_r.ctrl.pole_b21}))
      POLE_8: poles_now = POLES_8;
      POLE_16: poles_now = POLES_16;
      POLE_12: poles_now = POLES_12;
      // undefined code falls back to the smallest motor
      POLE_UNDEF: poles_now = POLES_8;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_prev = pin_s.cs_n;
    st_nxt.zc_prev = pin_s.zero_cross;
    st_nxt.tick_prev = tick_sel;
    st_nxt.fast = 1'b0;
    st_nxt.slow = 1'b0;

    // shift word is frozen while cs is high, so sampling after the sync is safe
    if (cs_rise) begin
      st_nxt.ctrl = ssmc_ctrl_s'(lnk_r.shift);
    end

    st_nxt.run = st_r.ctrl.sleep_run_bit;
    st_nxt.step = st_r.ctrl.step_only_bit;
    // step only leaves the startup oscillator as the sole commutation source
    st_nxt.bemf_en = st_r.ctrl.sleep_run_bit & ~st_r.ctrl.step_only_bit;
    st_nxt.ilim = {st_r.ctrl.ilim_b3, st_r.ctrl.ilim_b4};
    st_nxt.poles = poles_now;

    // latched: only reset releases it
    if (pin_s.brake || st_r.ctrl.brake_bit) begin
      st_nxt.brake = 1'b1;
    end

    // internal once-around: toggle every 3 x poles zero crossings
    if (!st_r.run) begin
      st_nxt.zc_cnt = '0;
    end else if (zc_edge) begin
      if (st_r.zc_cnt + 6'h01 >= zc_limit) begin
        st_nxt.zc_cnt = '0;
        st_nxt.int_tick = ~st_r.int_tick;
      end else begin
        st_nxt.zc_cnt = st_r.zc_cnt + 6'h01;
      end
    end

    // reference interval lasts exactly ref_total oscillator cycles
    if (tick_rise) begin
      st_nxt.ref_cnt = ref_total;
      st_nxt.ref_hi = (ref_total != '0);
    end else if (st_r.ref_hi) begin
      st_nxt.ref_cnt = st_r.ref_cnt - 18'h00001;
      st_nxt.ref_hi = (st_r.ref_cnt > 18'h00001);
    end

    // whichever edge falls first decides fast or slow
    if (tick_rise) begin
      st_nxt.armed = 1'b1;
      st_nxt.diff_cnt = '0;
    end else if (st_r.armed) begin
      if (tick_fall && st_r.ref_hi) begin
        st_nxt.fast = 1'b1;
      end
      if (!tick_sel && st_r.tick_prev == 1'b0 && st_r.ref_hi && !st_nxt.ref_hi) begin
        st_nxt.fast = 1'b0;
      end
      if (tick_sel && st_r.ref_hi && !st_nxt.ref_hi) begin
        st_nxt.slow = 1'b1;
      end
      if (tick_sel != st_r.ref_hi) begin
        st_nxt.diff_cnt = st_r.diff_cnt + 18'h00001;
      end
      if (!tick_sel && !st_r.ref_hi) begin
        st_nxt.armed = 1'b0;
        st_nxt.sync = (st_r.diff_cnt <= SYNC_TOL);
      end
    end

    // asleep means the next start is a fresh startup
    if (!st_r.ctrl.sleep_run_bit) begin
      st_nxt.preset = 1'b1;
    end else if (st_nxt.fast) begin
      st_nxt.preset = 1'b0;
    end

    unique case (ssmc_osel_e'({st_r.ctrl.osel_b22, st_r.ctrl.osel_b23}))
      OSEL_TICK: st_nxt.data_out = tick_sel;
      OSEL_THERM: st_nxt.data_out = pin_s.thermal;
      OSEL_SYNC: st_nxt.data_out = st_r.sync;
      OSEL_ZC: st_nxt.data_out = pin_s.zero_cross;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      // every control bit cleared, device in sleep
      st_r <= '{ctrl: ssmc_ctrl_s'(CW_RST), cs_prev: 1'b1, preset: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign run_o = st_r.run;
  assign step_only_o = st_r.step;
  assign bemf_commutate_en_o = st_r.bemf_en;
  assign high_side_off_o = st_r.brake;
  assign low_side_on_o = {3{st_r.brake}};
  assign current_limit_o = st_r.ilim;
  assign pole_count_o = st_r.poles;
  // while high the analog side bypasses the filter node at max current
  assign speed_loop_preset_o = st_r.preset;
  assign revolution_tick_o = st_r.tick_prev;
  assign speed_ref_o = st_r.ref_hi;
  assign speed_fast_o = st_r.fast;
  assign speed_slow_o = st_r.slow;
  assign speed_sync_o = st_r.sync;
  assign data_out_o = st_r.data_out;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_SHIFT: assert property (@(posedge sclk_i) disable iff (chip_sel_n_i)
    1'b1 |=> lnk_r.shift[0] == $past(serial_data_i))
    else $error("serial bit not shifted in");
  AST_LATCH: assert property (cs_rise |=> st_r.ctrl == $past(lnk_r.shift))
    else $error("word not latched on chip select rise");
  AST_HOLD: assert property (!cs_rise |=> $stable(st_r.ctrl))
    else $error("control word changed without chip select rise");
  // the default disable would make this vacuous, so it watches reset itself
  AST_SLEEP_RST: assert property (disable iff (1'b0)
    !nrst_i |=> !st_r.ctrl.sleep_run_bit ##1 !run_o)
    else $error("reset did not force sleep");
  AST_RUN: assert property (st_r.ctrl.sleep_run_bit |=> run_o)
    else $error("run output does not follow run bit");
  AST_BRAKE_ON: assert property (pin_s.brake |=> low_side_on_o == 3'h7 && high_side_off_o)
    else $error("brake pin did not engage brake");
  AST_BRAKE_KEEP: assert property (low_side_on_o == 3'h7 |=> low_side_on_o == 3'h7)
    else $error("brake released without reset");
  AST_PRESET_CLR: assert property (speed_fast_o && $past(run_o) |-> !speed_loop_preset_o)
    else $error("preset survived first overspeed");
  AST_PRESET_SLEEP: assert property (!st_r.ctrl.sleep_run_bit |=> speed_loop_preset_o)
    else $error("preset not armed at startup");
  AST_REF_START: assert property (tick_rise && ref_total == 18'h00010 |=>
    speed_ref_o [*8] ##1 speed_ref_o [*8] ##1 !speed_ref_o)
    else $error("reference interval length wrong");
  AST_ILIM: assert property (##1 current_limit_o == $past({st_r.ctrl.ilim_b3, st_r.ctrl.ilim_b4}))
    else $error("current limit code mismatch");
  AST_SRC: assert property (st_r.ctrl.speed_source_bit |=> revolution_tick_o == $past(pin_s.index))
    else $error("index not used as tick source");
  AST_DIAG_TH: assert property ({st_r.ctrl.osel_b22, st_r.ctrl.osel_b23} == 2'h1
    |=> data_out_o == $past(pin_s.thermal))
    else $error("diagnostic output not thermal flag");

  COV_WRITE: cover property (cs_rise ##1 run_o);
  COV_BRAKE: cover property ($rose(high_side_off_o));
  COV_FAST: cover property (speed_fast_o);
  COV_INDEX: cover property (st_r.ctrl.speed_source_bit && tick_rise);
endmodule

// >>> tb_spindle_serial_mode_control.sv
// self-checking bench of the spindle serial mode control block
// assumes ssmc_pkg and ssmc_host_model are compiled first
`timescale 1ns/1ps
module tb_spindle_serial_mode_control;
  import ssmc_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic brake_pin = 1'b0;
  logic index = 1'b0;
  logic zc = 1'b0;
  logic therm = 1'b1;
  logic sclk, cs_n, sdata, run, step, bemf, hs_off, preset, tick, ref_on;
  logic fast, slow, sync, dout, prev;
  logic [2:0] ls_on;
  logic [1:0] ilim;
  logic [4:0] poles;
  logic [23:0] w;
  int error_cnt = 0;
  int n_checks = 0;
  integer seed = 32'hf71c8b68;
  int pole_tab[4] = '{8, 8, 16, 12};
  int n, k, len, sl, fa;

  always #4 core_clk = ~core_clk;

  ssmc_host_model host (.sclk_o(sclk), .chip_sel_n_o(cs_n), .serial_data_o(sdata));

  ssmc_top DUT (.core_clk_i(core_clk), .nrst_i(nrst), .sclk_i(sclk),
    .chip_sel_n_i(cs_n), .serial_data_i(sdata), .brake_pin_i(brake_pin),
    .index_i(index), .zero_cross_toggle_i(zc), .thermal_shdn_i(therm),
    .run_o(run), .step_only_o(step), .bemf_commutate_en_o(bemf),
    .high_side_off_o(hs_off), .low_side_on_o(ls_on), .current_limit_o(ilim),
    .pole_count_o(poles), .speed_loop_preset_o(preset), .revolution_tick_o(tick),
    .speed_ref_o(ref_on), .speed_fast_o(fast), .speed_slow_o(slow),
    .speed_sync_o(sync), .data_out_o(dout));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  // extra leading clocks carry junk that must be shifted out
  task automatic wr(input logic [23:0] v, input int nclk);
    host.write_word({8'hc5, v}, nclk);
    cyc(4);
    w = v;
  endtask

  task automatic chk_word();
    chk("run", 32'(w[0]), 32'(run));
    chk("step", 32'(w[1]), 32'(step));
    chk("bemf", 32'(w[0] & ~w[1]), 32'(bemf));
    chk("ilim", 32'({w[3], w[4]}), 32'(ilim));
    chk("poles", pole_tab[{w[20], w[21]}], 32'(poles));
    chk("low_side", 0, 32'(ls_on));
  endtask

  // one tick pulse of hi+1 cycles, counting reference cycles and error pulses
  task automatic spd(input int hi);
    len = 0;
    sl = 0;
    fa = 0;
    index <= 1'b1;
    for (int c = 0; c < 60; c++) begin
      cyc(1);
      if (c == hi) index <= 1'b0;
      if (ref_on === 1'b1) len++;
      if (slow === 1'b1) sl++;
      if (fast === 1'b1) fa++;
    end
  endtask

  initial begin
    cyc(10);
    chk("preset", 1, 32'(preset));
    chk("run", 0, 32'(run));
    nrst <= 1'b1;
    cyc(4);
    for (int i = 0; i < 4; i++) begin
      w = 24'($random(seed));
      w[4:3] = 2'(i);
      w[21:20] = 2'(i);
      w[23:22] = 2'(i);
      w[2] = 1'b0;
      w[0] = (i != 1);
      wr(w, 24);
      chk_word();
      // i=2 puts code 01 (thermal) on bits 22/23; no revolution yet, so sync is low
      chk("dout", i == 2 ? 1 : 0, 32'(dout));
    end
    host.noise(30);
    cyc(4);
    chk_word();
    w = 24'($random(seed));
    w[2] = 1'b0;
    wr(w, 28);
    chk_word();
    // index mode and a 16-cycle count in one write, tick idle so sync is low
    wr(24'h0fffc1, 24);
    n = 0;
    for (int b = 0; b < 14; b++) if (!w[5 + b]) n += 16 << b;
    spd(50);
    chk("ref_len", n, len);
    chk("slow", 1, sl);
    chk("fast", 0, fa);
    chk("preset", 1, 32'(preset));
    spd(4);
    chk("fast", 1, fa);
    chk("preset", 0, 32'(preset));
    // tick fell about a dozen cycles before the reference, inside the window
    chk("sync", 1, 32'(sync));
    wr(24'h07ffc1, 24);
    prev = tick;
    k = 0;
    for (int e = 0; e < 49; e++) begin
      if (e < 48) zc <= ~zc;
      for (int c = 0; c < 4; c++) begin
        cyc(1);
        if (tick !== prev) k++;
        prev = tick;
      end
    end
    chk("ticks", 48 / (ZC_PER_POLE * pole_tab[{w[20], w[21]}]), k);
    brake_pin <= 1'b1;
    cyc(6);
    brake_pin <= 1'b0;
    cyc(6);
    chk("low_side", 7, 32'(ls_on));
    chk("high_off", 1, 32'(hs_off));
    nrst <= 1'b0;
    cyc(4);
    nrst <= 1'b1;
    cyc(2);
    chk("low_side", 0, 32'(ls_on));
    chk("run", 0, 32'(run));
    wr(24'h000005, 24);
    chk("low_side", 7, 32'(ls_on));
    wr(24'h000001, 24);
    chk("low_side", 7, 32'(ls_on));
    summarize();
  end
endmodule
